// File: include/nand_host_pkg.sv
// Shared constants, types and register map of the NAND program host
`default_nettype none
package nand_host_pkg;
    // Clock and pin timing
    localparam int CLK_PS = 8000;
    localparam int T_SETUP_NS = 10;
    localparam int T_WE_LOW_NS = 12;
    localparam int T_WE_HIGH_NS = 10;
    localparam int T_REA_NS = 20;
    localparam int T_WB_NS = 100;
    localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WE_LOW_CYC = (T_WE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WE_HIGH_CYC = (T_WE_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int REA_CYC = (T_REA_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WB_CYC = (T_WB_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SYNC_STAGES = 2;

    // APB register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] COL_OFS = 8'h04;
    localparam logic [7:0] ROW0_OFS = 8'h08;
    localparam logic [7:0] ROW1_OFS = 8'h0c;
    localparam logic [7:0] DATA_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;

    // Field positions
    localparam int CTRL_WP_BIT = 8;
    localparam int ST_BUSY_BIT = 8;
    localparam int ST_INDATA_BIT = 9;
    localparam int ST_DUMMY_BIT = 10;
    localparam int ST_CACHE_BIT = 11;
    localparam int ST_ERR_BIT = 12;
    localparam int PAGE_BITS = 6;
    localparam int DISTRICT_BIT = 6;

    // Device command bytes
    localparam logic [7:0] CMD_LOAD = 8'h80;
    localparam logic [7:0] CMD_PLANE2 = 8'h81;
    localparam logic [7:0] CMD_COLCHG = 8'h85;
    localparam logic [7:0] CMD_PROG = 8'h10;
    localparam logic [7:0] CMD_CACHE = 8'h15;
    localparam logic [7:0] CMD_DUMMY = 8'h11;
    localparam logic [7:0] CMD_STAT = 8'h70;
    localparam logic [7:0] CMD_STAT_DIST = 8'h71;
    localparam logic [7:0] CMD_RESET = 8'hff;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_LOAD = 4'h1,
        OP_PLANE2 = 4'h2,
        OP_COLCHG = 4'h3,
        OP_CONF_PROG = 4'h4,
        OP_CONF_CACHE = 4'h5,
        OP_CONF_DUMMY = 4'h6,
        OP_STAT = 4'h7,
        OP_STAT_DIST = 4'h8,
        OP_RESET = 4'h9
    } op_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BUS = 4'b0010,
        ST_READ = 4'b0100,
        ST_WAIT = 4'b1000
    } state_e;

    // Pins driven toward the flash device
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic wp_n;
        logic [7:0] io_out;
        logic io_oe_n;
    } nand_pins_s;
endpackage
`default_nettype wire

// File: rtl/nand_cycle_strobe.sv
// One write or read strobe cycle on the flash bus
`timescale 1ns/1ps
`default_nettype none
module nand_cycle_strobe #(
    parameter int SETUP = 2,
    parameter int LOW = 2,
    parameter int HIGH = 2,
    parameter int READ_EXTRA = 2
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic start,
    input wire logic read,
    input wire logic [7:0] io_sync,
    output logic we_n,
    output logic re_n,
    output logic busy,
    output logic done,
    output logic [7:0] rdata
);
    logic [1:0] phase;
    logic [7:0] count;
    logic is_read;

    // Read low time also covers the pin synchroniser delay
    wire [7:0] low_len = is_read ? 8'(LOW + READ_EXTRA) : 8'(LOW);
    wire last = (count == 8'h01);
    assign busy = (phase != 2'h0);
    assign done = (phase == 2'h3) && last;

    // Setup, strobe low, strobe high
    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase <= 2'h0;
            count <= 8'h00;
            is_read <= 1'b0;
            we_n <= 1'b1;
            re_n <= 1'b1;
            rdata <= 8'h00;
        end else if (clk_en) begin
            case (phase)
                2'h0: if (start) begin
                    phase <= 2'h1;
                    count <= 8'(SETUP);
                    is_read <= read;
                end
                2'h1: if (last) begin
                    phase <= 2'h2;
                    count <= low_len;
                    we_n <= is_read;
                    re_n <= !is_read;
                end else begin
                    count <= count - 8'h01;
                end
                2'h2: if (last) begin
                    phase <= 2'h3;
                    count <= 8'(HIGH);
                    we_n <= 1'b1;
                    re_n <= 1'b1;
                    if (is_read) begin
                        rdata <= io_sync;
                    end
                end else begin
                    count <= count - 8'h01;
                end
                default: if (last) begin
                    phase <= 2'h0;
                end else begin
                    count <= count - 8'h01;
                end
            endcase
        end
    end
endmodule // nand_cycle_strobe
`default_nettype wire

// File: rtl/nand_program_host.sv
// Host sequencer for paged, cached and dual-district flash programming
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Dual-district pages: one block per district, identical page bits.
// - Keep write-protect high throughout the dual-district operation; the opening load order's own write can still lower it.
// - Between dummy confirm and second-plane setup only status or reset.
// - Cached sequence ends with normal confirm; ready after final page.
// - Block address change restarts cached sequence from its beginning; here a load on another block during a cached run is refused.
// - Full dual cached run ends with second-plane setup then normal confirm.
// - Order: load, address, dummy, plane two, address, confirm, same page.
// - Dual cached run ends with normal confirm; only status or reset besides.
module nand_program_host (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ready_busy_pin,
    input wire logic [7:0] io_in,
    output nand_host_pkg::nand_pins_s pins
);
    nand_host_pkg::state_e state;
    logic [11:0] col;
    logic [16:0] row0;
    logic [16:0] row1;
    logic wp_en;
    logic [7:0] status;
    logic in_data;
    logic after_dummy;
    logic cache_active;
    logic [10:0] cache_block;
    logic err;
    logic [7:0] seq_byte [0:5];
    logic [2:0] seq_len;
    logic [2:0] idx;
    logic has_cmd;
    logic do_read;
    logic do_wait;
    logic [7:0] wait_cnt;
    logic rb_meta;
    logic rb_sync;
    logic [7:0] io_meta;
    logic [7:0] io_sync;
    logic cle;
    logic ale;
    logic ce_n;
    logic [7:0] io_out;
    logic stb_busy;
    logic stb_done;
    logic stb_we_n;
    logic stb_re_n;
    logic [7:0] stb_rdata;

    // APB decode
    wire access = psel && penable;
    wire hit_ctrl = (paddr == nand_host_pkg::CTRL_OFS);
    wire hit_data = (paddr == nand_host_pkg::DATA_OFS);
    wire hit_stat = (paddr == nand_host_pkg::STATUS_OFS);
    wire hit_col = (paddr == nand_host_pkg::COL_OFS);
    wire hit_row0 = (paddr == nand_host_pkg::ROW0_OFS);
    wire hit_row1 = (paddr == nand_host_pkg::ROW1_OFS);
    wire mapped = hit_ctrl || hit_data || hit_stat || hit_col || hit_row0 || hit_row1;
    // Orders wait for the engine; this stalls software instead of dropping work
    wire hold = pwrite && (hit_ctrl || hit_data) && (state != nand_host_pkg::ST_IDLE);
    assign pready = !hold;
    assign pslverr = access && !mapped;
    wire wr = access && pready && pwrite && mapped;
    wire ord = wr && hit_ctrl;
    wire [3:0] op_raw = pwdata[3:0];
    wire op_is_cmd = (op_raw != 4'h0);
    wire data_go = wr && hit_data;

    // Address fields: page bits, block, district by block parity
    wire [5:0] page0 = row0[nand_host_pkg::PAGE_BITS-1:0];
    wire [5:0] page1 = row1[nand_host_pkg::PAGE_BITS-1:0];
    wire [10:0] block0 = row0[16:6];
    wire dist0 = row0[nand_host_pkg::DISTRICT_BIT];
    wire dist1 = row1[nand_host_pkg::DISTRICT_BIT];

    wire block_ok = !cache_active || (block0 == cache_block);
    wire ok_load = !in_data && !after_dummy && wp_en && block_ok;
    // one block per district, same page bits
    wire ok_plane2 = after_dummy && wp_en && (dist0 != dist1) && (page0 == page1);
    wire ok_conf = in_data;
    // only status or reset between dummy and plane two
    wire ok_dummy_gap = !after_dummy;

    // Legality of each order
    logic legal;
    always_comb begin
        case (op_raw)
            4'h1: legal = ok_load;
            4'h2: legal = ok_plane2;
            4'h3: legal = ok_conf;
            4'h4: legal = ok_conf && ok_dummy_gap;
            4'h5: legal = ok_conf && ok_dummy_gap;
            4'h6: legal = ok_conf && ok_dummy_gap;
            4'h7: legal = 1'b1;
            4'h8: legal = 1'b1;
            4'h9: legal = 1'b1;
            default: legal = 1'b0;
        endcase
    end
    wire accept = ord && op_is_cmd && legal;
    wire refuse = ord && op_is_cmd && !legal;
    wire op_load = accept && (op_raw == nand_host_pkg::OP_LOAD);
    wire op_plane2 = accept && (op_raw == nand_host_pkg::OP_PLANE2);
    wire op_colchg = accept && (op_raw == nand_host_pkg::OP_COLCHG);
    wire op_prog = accept && (op_raw == nand_host_pkg::OP_CONF_PROG);
    wire op_cache = accept && (op_raw == nand_host_pkg::OP_CONF_CACHE);
    wire op_dummy = accept && (op_raw == nand_host_pkg::OP_CONF_DUMMY);
    wire op_stat = accept && (op_raw == nand_host_pkg::OP_STAT);
    wire op_sdist = accept && (op_raw == nand_host_pkg::OP_STAT_DIST);
    wire op_reset = accept && (op_raw == nand_host_pkg::OP_RESET);
    wire data_ok = data_go && in_data && !after_dummy;

    // Command byte of the accepted order
    logic [7:0] cmd_byte;
    always_comb begin
        case (op_raw)
            4'h1: cmd_byte = nand_host_pkg::CMD_LOAD;
            4'h2: cmd_byte = nand_host_pkg::CMD_PLANE2;
            4'h3: cmd_byte = nand_host_pkg::CMD_COLCHG;
            4'h4: cmd_byte = nand_host_pkg::CMD_PROG;
            4'h5: cmd_byte = nand_host_pkg::CMD_CACHE;
            4'h6: cmd_byte = nand_host_pkg::CMD_DUMMY;
            4'h7: cmd_byte = nand_host_pkg::CMD_STAT;
            4'h8: cmd_byte = nand_host_pkg::CMD_STAT_DIST;
            default: cmd_byte = nand_host_pkg::CMD_RESET;
        endcase
    end
    wire [16:0] row_sel = op_plane2 ? row1 : row0;
    wire with_row = op_load || op_plane2;
    wire with_col = with_row || op_colchg;
    wire [2:0] next_len = with_row ? 3'h6 : (with_col ? 3'h3 : 3'h1);
    wire last_byte = (idx == seq_len - 3'h1);

    // Pin synchronisers, second stage only is read
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rb_meta <= 1'b1;
            rb_sync <= 1'b1;
            io_meta <= 8'h00;
            io_sync <= 8'h00;
        end else if (clk_en) begin
            rb_meta <= ready_busy_pin;
            rb_sync <= rb_meta;
            io_meta <= io_in;
            io_sync <= io_meta;
        end
    end

    nand_cycle_strobe #(
        .SETUP(nand_host_pkg::SETUP_CYC),
        .LOW(nand_host_pkg::REA_CYC > nand_host_pkg::WE_LOW_CYC ?
            nand_host_pkg::REA_CYC : nand_host_pkg::WE_LOW_CYC),
        .HIGH(nand_host_pkg::WE_HIGH_CYC),
        .READ_EXTRA(nand_host_pkg::SYNC_STAGES)
    ) strobe (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .start((state == nand_host_pkg::ST_BUS || state == nand_host_pkg::ST_READ) && !stb_busy),
        .read(state == nand_host_pkg::ST_READ),
        .io_sync(io_sync),
        .we_n(stb_we_n),
        .re_n(stb_re_n),
        .busy(stb_busy),
        .done(stb_done),
        .rdata(stb_rdata)
    );

    // Software registers and sequence tracking
    always_ff @(posedge core_clk) begin
        if (reset) begin
            col <= 12'h000;
            row0 <= 17'h00000;
            row1 <= 17'h00000;
            wp_en <= 1'b0;
            in_data <= 1'b0;
            after_dummy <= 1'b0;
            cache_active <= 1'b0;
            cache_block <= 11'h000;
            err <= 1'b0;
        end else if (clk_en) begin
            if (wr && hit_col) col <= pwdata[11:0];
            if (wr && hit_row0) row0 <= pwdata[16:0];
            if (wr && hit_row1) row1 <= pwdata[16:0];
            // protect level frozen while a program run is open
            if (ord && !in_data && !cache_active && !after_dummy) begin
                wp_en <= pwdata[nand_host_pkg::CTRL_WP_BIT];
            end
            // Refusal wins over a clear in the same write cycle
            if (refuse || (data_go && !data_ok)) begin
                err <= 1'b1;
            end else if (wr && hit_stat && pwdata[nand_host_pkg::ST_ERR_BIT]) begin
                err <= 1'b0;
            end
            if (op_load || op_plane2) in_data <= 1'b1;
            else if (op_prog || op_cache || op_dummy || op_reset) in_data <= 1'b0;
            // dummy confirm opens the second-plane slot
            if (op_dummy) after_dummy <= 1'b1;
            else if (op_plane2 || op_reset) after_dummy <= 1'b0;
            // normal confirm closes a cached run
            if (op_cache) cache_active <= 1'b1;
            else if (op_prog || op_reset) cache_active <= 1'b0;
            if (op_load && !cache_active) cache_block <= block0;
        end
    end

    // Byte sequencer and busy wait
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= nand_host_pkg::ST_IDLE;
            for (int i = 0; i < 6; i++) seq_byte[i] <= 8'h00;
            seq_len <= 3'h0;
            idx <= 3'h0;
            has_cmd <= 1'b0;
            do_read <= 1'b0;
            do_wait <= 1'b0;
            wait_cnt <= 8'h00;
            status <= nand_host_pkg::STATUS_RST;
        end else if (clk_en) begin
            case (state)
                nand_host_pkg::ST_IDLE: if (accept || data_ok) begin
                    state <= nand_host_pkg::ST_BUS;
                    idx <= 3'h0;
                    has_cmd <= accept;
                    seq_len <= accept ? next_len : 3'h1;
                    seq_byte[0] <= accept ? cmd_byte : pwdata[7:0];
                    seq_byte[1] <= col[7:0];
                    seq_byte[2] <= {4'h0, col[11:8]};
                    seq_byte[3] <= row_sel[7:0];
                    seq_byte[4] <= row_sel[15:8];
                    seq_byte[5] <= {7'h00, row_sel[16]};
                    do_read <= op_stat || op_sdist;
                    do_wait <= op_prog || op_cache || op_dummy || op_reset;
                end
                nand_host_pkg::ST_BUS: if (stb_done) begin
                    idx <= idx + 3'h1;
                    wait_cnt <= 8'(nand_host_pkg::WB_CYC);
                    if (last_byte) begin
                        // status byte read without waiting for ready
                        if (do_read) state <= nand_host_pkg::ST_READ;
                        else if (do_wait) state <= nand_host_pkg::ST_WAIT;
                        else state <= nand_host_pkg::ST_IDLE;
                    end
                end
                nand_host_pkg::ST_READ: if (stb_done) begin
                    status <= stb_rdata;
                    state <= nand_host_pkg::ST_IDLE;
                end
                nand_host_pkg::ST_WAIT: begin
                    // idle only once the device reports ready again
                    if (wait_cnt != 8'h00) wait_cnt <= wait_cnt - 8'h01;
                    else if (rb_sync) state <= nand_host_pkg::ST_IDLE;
                end
                default: state <= nand_host_pkg::ST_IDLE;
            endcase
        end
    end

    // Pin levels registered ahead of the strobe edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cle <= 1'b0;
            ale <= 1'b0;
            ce_n <= 1'b1;
            io_out <= 8'h00;
        end else if (clk_en) begin
            cle <= (state == nand_host_pkg::ST_BUS) && has_cmd && (idx == 3'h0);
            ale <= (state == nand_host_pkg::ST_BUS) && has_cmd && (idx != 3'h0);
            ce_n <= 1'b0;
            io_out <= seq_byte[idx];
        end
    end

    assign pins.ce_n = ce_n;
    assign pins.cle = cle;
    assign pins.ale = ale;
    assign pins.we_n = stb_we_n;
    assign pins.re_n = stb_re_n;
    assign pins.wp_n = wp_en;
    assign pins.io_out = io_out;
    assign pins.io_oe_n = (state == nand_host_pkg::ST_READ);

    // Register read mux
    wire [31:0] status_word = {19'h0, err, cache_active, after_dummy, in_data,
        (state != nand_host_pkg::ST_IDLE), status};
    assign prdata = hit_ctrl ? {23'h0, wp_en, 8'h00} :
        hit_col ? {20'h0, col} :
        hit_row0 ? {15'h0, row0} :
        hit_row1 ? {15'h0, row1} :
        hit_stat ? status_word : 32'h0;

    // Assertions
    a_wp_held_open: assert property (@(posedge core_clk) disable iff (reset)
        (in_data || cache_active || after_dummy) |-> pins.wp_n)
        else $error("write protect dropped during program run");
    a_dummy_gap_only: assert property (@(posedge core_clk) disable iff (reset)
        (accept && after_dummy) |-> (op_raw >= 4'h7 || op_raw == 4'h2))
        else $error("forbidden order between dummy and plane two");
    a_page_match: assert property (@(posedge core_clk) disable iff (reset)
        op_plane2 |-> (page0 == page1) && (dist0 != dist1))
        else $error("second plane page or district mismatch");
    a_block_restart: assert property (@(posedge core_clk) disable iff (reset)
        (op_load && cache_active) |-> (block0 == cache_block))
        else $error("cached run continued on new block");
    a_plane2_order: assert property (@(posedge core_clk) disable iff (reset)
        (op_dummy && clk_en) |=> after_dummy && !in_data)
        else $error("dummy confirm did not open second plane slot");
    a_final_confirm: assert property (@(posedge core_clk) disable iff (reset)
        (op_prog && clk_en) |=> !cache_active ##0 (state == nand_host_pkg::ST_BUS))
        else $error("normal confirm did not close cached run");
    a_run_end_order: assert property (@(posedge core_clk) disable iff (reset)
        (op_prog && cache_active) |-> !after_dummy && in_data)
        else $error("final confirm outside an open load");
endmodule // nand_program_host
`default_nettype wire

// File: tb/nand_flash_model.sv
// Behavioural flash device answering the program host's pins
`timescale 1ns/1ps
`default_nettype none
module nand_flash_model (
    input wire logic core_clk,
    input wire logic fail_odd,
    input wire nand_host_pkg::nand_pins_s pins,
    output logic ready_busy_pin,
    output logic [7:0] io_in
);
    logic [9:0] log_b [0:127];
    int n_log = 0;
    int busy = 0;
    int acnt = 0;
    logic we_q = 1'b1;
    logic [1:0] sel = 2'b00;
    logic [1:0] f = 2'b00;
    logic prev = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic [7:0] st;
    logic rdy;
    assign rdy = (busy == 0);
    assign ready_busy_pin = rdy;
    assign st = (cmd == 8'h71) ? {pins.wp_n, rdy, rdy, 2'b00, f, |f}
                               : {pins.wp_n, rdy, rdy, 3'b000, prev, |f};
    // Byte capture on strobe rise
    always @(posedge core_clk) begin
        we_q <= pins.we_n;
        if (busy > 0) busy <= busy - 1;
        // Released bus shows the inverse so a stale byte cannot match
        io_in <= pins.re_n ? ~st : st;
        if (!we_q && pins.we_n) begin
            log_b[n_log] <= {pins.cle, pins.ale, pins.io_out};
            n_log <= n_log + 1;
            acnt <= pins.ale ? acnt + 1 : 0;
            if (pins.ale && acnt == 2 && cmd != 8'h85) sel[pins.io_out[6]] <= 1'b1;
            if (pins.cle) begin
                cmd <= pins.io_out;
                if (pins.io_out == 8'h80) sel <= 2'b00;
                if (pins.io_out == 8'h10 || pins.io_out == 8'h15) begin
                    busy <= busy + ((pins.io_out == 8'h15) ? 20 : 60);
                    prev <= |f;
                    f <= {fail_odd & sel[1], 1'b0};
                end
            end
        end
    end
endmodule // nand_flash_model
`default_nettype wire

// File: tb/nand_program_host_tb_top.sv
// Self-checking bench for the flash program host
`timescale 1ns/1ps
`default_nettype none
module nand_program_host_tb_top;
    logic core_clk;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ready_busy_pin;
    logic [7:0] io_in;
    nand_host_pkg::nand_pins_s pins;
    logic fail_odd = 1'b0;
    logic [31:0] rd;
    logic er;
    logic rb_low = 1'b0;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int b;
    nand_program_host u_nand_program_host (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ready_busy_pin(ready_busy_pin),
        .io_in(io_in), .pins(pins));
    nand_flash_model u_nand_flash_model (.core_clk(core_clk), .fail_odd(fail_odd),
        .pins(pins), .ready_busy_pin(ready_busy_pin), .io_in(io_in));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Hang guard, far beyond the expected run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (!ready_busy_pin) rb_low <= 1'b1;
        if (cyc == 20000) begin
            fails++;
            conclude;
        end
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits an edge so psel never changes twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // write-protect kept released in every order
    task automatic ctrl(input logic [3:0] op);
        wr(nand_host_pkg::CTRL_OFS, 32'h100 | op);
    endtask
    task automatic idle;
        do apb(1'b0, nand_host_pkg::STATUS_OFS, 32'h0); while (rd[8] !== 1'b0);
    endtask
    task automatic stc(input logic [3:0] op, input logic [7:0] exp);
        ctrl(op);
        idle;
        chk(rd[7:0], exp);
    endtask
    task automatic page(input logic [7:0] op, input logic [16:0] row, input logic [7:0] d);
        wr(op == 1 ? nand_host_pkg::ROW0_OFS : nand_host_pkg::ROW1_OFS, row);
        ctrl(op[3:0]);
        wr(nand_host_pkg::DATA_OFS, d);
    endtask
    task automatic t_prog;
        logic [9:0] q[$];
        b = u_nand_flash_model.n_log;
        ctrl(4'h0);
        wr(nand_host_pkg::COL_OFS, 32'h123);
        page(1, 17'h45, 8'ha5);
        wr(nand_host_pkg::COL_OFS, 32'h010);
        ctrl(4'h3);
        wr(nand_host_pkg::DATA_OFS, 32'h5a);
        ctrl(4'h4);
        idle;
        q = '{10'h280, 10'h123, 10'h101, 10'h145, 10'h100, 10'h100, 10'h0a5,
              10'h285, 10'h110, 10'h100, 10'h05a, 10'h210};
        foreach (q[i]) chk(u_nand_flash_model.log_b[b + i], q[i]);
        chk(rb_low, 1'b1);
        stc(4'h7, 8'he0);
        $display("page program test done");
    endtask
    // odd district first, same page, dummy then plane two
    task automatic t_dual;
        fail_odd <= 1'b1;
        b = u_nand_flash_model.n_log;
        page(1, 17'h45, 8'h11);
        ctrl(4'h6);
        page(2, 17'h85, 8'h22);
        ctrl(4'h4);
        idle;
        chk(u_nand_flash_model.log_b[b + 7], 10'h211);
        chk(u_nand_flash_model.log_b[b + 8], 10'h281);
        chk(u_nand_flash_model.log_b[b + 15], 10'h210);
        stc(4'h8, 8'he5);
        stc(4'h7, 8'he1);
        $display("dual district test done");
    endtask
    task automatic t_refuse;
        fail_odd <= 1'b0;
        page(1, 17'h85, 8'h33);
        ctrl(4'h6);
        idle;
        b = u_nand_flash_model.n_log;
        wr(nand_host_pkg::ROW1_OFS, 17'h105);
        ctrl(4'h2);
        idle;
        chk(rd[12], 1'b1);
        chk(u_nand_flash_model.n_log, b);
        ctrl(4'h9);
        wr(nand_host_pkg::STATUS_OFS, 32'h1000);
        idle;
        chk(rd[12], 1'b0);
        apb(1'b0, 8'h18, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("refusal test done");
    endtask
    // one block throughout, ended by normal confirm
    task automatic t_cache;
        fail_odd <= 1'b1;
        b = u_nand_flash_model.n_log;
        page(1, 17'h45, 8'h44);
        ctrl(4'h5);
        page(1, 17'h46, 8'h55);
        ctrl(4'h5);
        idle;
        fail_odd <= 1'b0;
        page(1, 17'h47, 8'h66);
        ctrl(4'h4);
        idle;
        chk(u_nand_flash_model.log_b[b + 7], 10'h215);
        chk(u_nand_flash_model.log_b[b + 15], 10'h215);
        chk(u_nand_flash_model.log_b[b + 23], 10'h210);
        stc(4'h7, 8'he2);
        $display("cached program test done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        idle;
        chk(rd, 32'h0);
        t_prog;
        t_dual;
        t_refuse;
        t_cache;
        conclude;
    end
endmodule // nand_program_host_tb_top
`default_nettype wire
